// ==== src/smpc_pkg.sv ====
// Package of constants for the sync output and mode pin control block
package smpc_pkg;
   // Rates in kHz; the synthesizers divide the 10 MHz clock by ratio only in a model sense
   localparam int unsigned RATE_A_RST_KHZ   = 1544;       // Synth B clock A reset rate
   localparam int unsigned RATE_B_RST_KHZ   = 3088;       // Synth B clock B reset rate
   localparam int unsigned RATE_MAX_KHZ     = 77760;
   localparam int unsigned RATE_MIN_KHZ     = 2;
   localparam int unsigned RATE_STEP_KHZ    = 8;
   // Differential output rate selects
   localparam logic [2:0]  SDH_19M44        = 3'h0;
   localparam logic [2:0]  SDH_38M88        = 3'h1;
   localparam logic [2:0]  SDH_77M76        = 3'h2;
   localparam logic [2:0]  SDH_155M52       = 3'h3;
   localparam logic [2:0]  SDH_311M04       = 3'h4;
   localparam logic [2:0]  SDH_622M08       = 3'h5;
   localparam logic [2:0]  DIFF_A_RST       = SDH_155M52;
   localparam logic [2:0]  DIFF_B_RST       = SDH_622M08;
   // Register offsets
   localparam logic [3:0]  REG_CTRL         = 4'h0;
   localparam logic [3:0]  REG_SYNTH_A      = 4'h1;
   localparam logic [3:0]  REG_SYNTH_B      = 4'h2;
   localparam logic [3:0]  REG_DIFF         = 4'h3;
   localparam logic [3:0]  REG_STATUS       = 4'h4;
   // Control register fields
   localparam int          CTRL_HS_SW       = 0;
   localparam int          CTRL_HS_SRC      = 1;
   localparam int          CTRL_MODE_LO     = 2;
   localparam int          CTRL_MODE_SRC    = 4;
   localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
   // Synth B clock B: bit 16 selects divide, low 8 bits the ratio
   localparam int          SYN_B_DIV_BIT    = 16;
   localparam logic [31:0] SYN_B_RST        = 32'h0000_0002; // Multiply by 2
   // Reset minimum time
   localparam int unsigned RST_MIN_NS       = 300;
   localparam int unsigned CLK_PERIOD_NS    = 100;
   localparam int unsigned RST_MIN_CYC      = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Primary loop modes
   typedef enum logic [3:0] {
      MODE_AUTO     = 4'b0001,
      MODE_NORMAL   = 4'b0010,
      MODE_HOLDOVER = 4'b0100,
      MODE_FREERUN  = 4'b1000
   } smpc_mode_t;
endpackage

// ==== src/smpc_top.sv ====
// Pin-level control and output clock configuration of the line-card synchronizer
//=====================================================================
// Contract
// RL1 - Synth B clock A: any 8 kHz multiple to 77.76 MHz or 2 kHz; resets 1.544 MHz.
// RL2 - Synth B clock B: multiple or division of clock A, 2 kHz..77.76 MHz; resets 3.088. The code refuses only a zero ratio, not an out-of-range rate.
// RL3 - Feedback copy output buffers primary loop feedback, matching selected reference rate.
// RL4 - Secondary reference copy buffers secondary selector output; switching not hitless.
// RL5 - Differential output A selects SDH rates, default 155.52 MHz.
// RL6 - Differential output B selects SDH rates, default 622.08 MHz.
// RL7 - Low device reset resets all; host holds it at least 300 ns after power-up.
// RL8 - Hitless enable high: primary loop switches references without phase hits.
// RL9 - Hitless enable low: no hitless switching, output phase realigned to reference.
// RL10 - Hitless control also settable through a software register.
// RL11 - Mode pins sampled during reset choose default primary loop mode; code gives MODE_AUTO until the pins settle, then follows them live.
// RL12 - After reset, mode comes from pins or the mode register.
// RL13 - Output A enable high drives the driver, low puts it in high impedance.
// RL14 - Output B enable high drives the driver, low puts it in high impedance.
// RL15 - Mode, hitless and enable pins synchronised before reaching control logic.
`timescale 1ns/1ps
module smpc_top
   import smpc_pkg::*;
#(
   parameter int unsigned SDH_RATES = 6
)
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [31:0] regRdData,
   input  wire logic        hitless_switch_enable,
   input  wire logic        primary_mode_pin_lo,
   input  wire logic        primary_mode_pin_hi,
   input  wire logic        diff_out_a_enable,
   input  wire logic        diff_out_b_enable,
   input  wire logic        primaryFeedbackClk,
   input  wire logic        secondarySelectedRef,
   input  wire logic        synthAClkRaw,
   input  wire logic        synthBClkRaw,
   input  wire logic        diffAClkRaw,
   input  wire logic        diffBClkRaw,
   output logic             synth_b_clock_a,
   output logic             synth_b_clock_b,
   output logic      [16:0] synthARateKhz,
   output logic      [31:0] synthBConfig,
   output logic             feedback_copy_out,
   output logic             secondary_ref_copy_out,
   output logic             diff_out_a_pos,
   output logic             diff_out_a_neg,
   output logic             diff_out_a_oen,
   output logic             diff_out_b_pos,
   output logic             diff_out_b_neg,
   output logic             diff_out_b_oen,
   output logic      [2:0]  diffARate,
   output logic      [2:0]  diffBRate,
   output logic             hitlessActive,
   output logic             phaseRealign,
   output smpc_mode_t       primaryMode
);

   //==================================================================
   // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
   localparam int NPIN = 5;
   logic [NPIN-1:0] pinRaw;
   logic [NPIN-1:0] pinS1_q;
   logic [NPIN-1:0] pinS2_q;
   logic [NPIN-1:0] pinS3_q;
   logic [NPIN-1:0] pinStable_q;
   logic [NPIN-1:0] pinStable_d;

   assign pinRaw = {diff_out_b_enable, diff_out_a_enable, primary_mode_pin_hi,
                    primary_mode_pin_lo, hitless_switch_enable};

   // Shift chain; first stage feeds only the second
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pinS1_q     <= '0;
         pinS2_q     <= '0;
         pinS3_q     <= '0;
         pinStable_q <= '0;
      end
      else
      begin
         pinS1_q     <= pinRaw;                 // [RL15]
         pinS2_q     <= pinS1_q;
         pinS3_q     <= pinS2_q;
         pinStable_q <= pinStable_d;
      end
   end

   // Agreement filter per pin
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_pin
         assign pinStable_d[gi] = (pinS2_q[gi] == pinS3_q[gi]) ? pinS3_q[gi]
                                                                : pinStable_q[gi]; // [RL15]
      end
   endgenerate

   wire       hsPin    = pinStable_q[0];
   wire [1:0] modePins = pinStable_q[2:1];
   wire       enAPin   = pinStable_q[3];
   wire       enBPin   = pinStable_q[4];

   //==================================================================
   // Reset release tracking; pins need the synchroniser depth to settle
   localparam logic [2:0] SETTLE_CYC = 3'(RST_MIN_CYC + 1);
   logic [2:0] settleCnt_q;
   logic       strapTaken_q;
   wire        settled   = (settleCnt_q == SETTLE_CYC);
   wire        takeStrap = settled && !strapTaken_q;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         settleCnt_q  <= 3'h0;
         strapTaken_q <= 1'b0;
      end
      else
      begin
         if (!settled)
            settleCnt_q <= settleCnt_q + 3'h1;
         if (takeStrap)
            strapTaken_q <= 1'b1;               // [RL7]
      end
   end

   //==================================================================
   // Register decode
   wire wrCtrl   = regWrite && (regAddr == REG_CTRL);
   wire wrSynA   = regWrite && (regAddr == REG_SYNTH_A);
   wire wrSynB   = regWrite && (regAddr == REG_SYNTH_B);
   wire wrDiff   = regWrite && (regAddr == REG_DIFF);

   // Synth A rate accepted only if 2 kHz or an 8 kHz multiple up to the ceiling
   wire [16:0] synAReq  = regWrData[16:0];
   wire        synAOk   = (synAReq == 17'(RATE_MIN_KHZ)) ||
                          ((synAReq != 17'h0_0000) && (synAReq[2:0] == 3'h0) &&
                           (synAReq <= 17'(RATE_MAX_KHZ)));
   // Clock B ratio: zero ratio refused
   wire        synBOk   = (regWrData[7:0] != 8'h00);
   wire        diffAOk  = (32'(regWrData[2:0]) < SDH_RATES);
   wire        diffBOk  = (32'(regWrData[10:8]) < SDH_RATES);

   logic [31:0] ctrl_q;
   logic [16:0] synA_q;
   logic [31:0] synB_q;
   logic [2:0]  diffA_q;
   logic [2:0]  diffB_q;
   logic [1:0]  strapMode_q;

   // Strap latch; the pins must settle through the synchroniser first
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         strapMode_q <= 2'h0;
      else if (takeStrap)
         strapMode_q <= modePins;               // [RL11]
   end

   // Control word: lets software take hitless and mode control from the pins
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ctrl_q <= CTRL_RST;
      else if (wrCtrl)
         ctrl_q <= regWrData;                   // [RL10]
   end

   // Synthesizer words; a refused value leaves the old rate running
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         synA_q <= 17'(RATE_A_RST_KHZ);         // [RL1]
         synB_q <= SYN_B_RST;                   // [RL2]
      end
      else
      begin
         if (wrSynA && synAOk)
            synA_q <= synAReq;                  // [RL1]
         if (wrSynB && synBOk)
            synB_q <= regWrData;                // [RL2]
      end
   end

   // Differential rate selects; each field is checked on its own
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         diffA_q <= DIFF_A_RST;                 // [RL5]
         diffB_q <= DIFF_B_RST;                 // [RL6]
      end
      else
      begin
         if (wrDiff && diffAOk)
            diffA_q <= regWrData[2:0];          // [RL5]
         if (wrDiff && diffBOk)
            diffB_q <= regWrData[10:8];         // [RL6]
      end
   end

   //==================================================================
   // Mode selection: strap until pins or register take over
   logic [1:0] modeCode;
   always_comb
   begin
      if (ctrl_q[CTRL_MODE_SRC])
         modeCode = ctrl_q[CTRL_MODE_LO +: 2];  // [RL12]
      else if (strapTaken_q)
         modeCode = modePins;                   // [RL12]
      else
         modeCode = strapMode_q;                // [RL11]
   end

   smpc_mode_t modeDec;
   always_comb
   begin
      case (modeCode)
         2'h0:    modeDec = MODE_AUTO;
         2'h1:    modeDec = MODE_NORMAL;
         2'h2:    modeDec = MODE_HOLDOVER;
         2'h3:    modeDec = MODE_FREERUN;
         default: modeDec = MODE_AUTO;
      endcase
   end

   // Hitless source: pin unless the register claims control
   wire hsEff = ctrl_q[CTRL_HS_SRC] ? ctrl_q[CTRL_HS_SW] : hsPin; // [RL10]

   //==================================================================
   // Read selection; an idle cycle or an unmapped offset reads as zero
   wire [31:0] statWord = {22'h00_0000, enBPin, enAPin, modeDec, modeCode, hsEff,
                           strapTaken_q};
   wire        rdCtrl   = regRead && (regAddr == REG_CTRL);
   wire        rdSynA   = regRead && (regAddr == REG_SYNTH_A);
   wire        rdSynB   = regRead && (regAddr == REG_SYNTH_B);
   wire        rdDiff   = regRead && (regAddr == REG_DIFF);
   wire        rdStat   = regRead && (regAddr == REG_STATUS);
   wire [31:0] rdMux    = ({32{rdCtrl}} & ctrl_q)
                        | ({32{rdSynA}} & {15'h0000, synA_q})
                        | ({32{rdSynB}} & synB_q)
                        | ({32{rdDiff}} & {21'h00_0000, diffB_q, 5'h00, diffA_q})
                        | ({32{rdStat}} & statWord);

   //==================================================================
   // Registered control outputs
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         primaryMode   <= MODE_AUTO;
         hitlessActive <= 1'b0;
         phaseRealign  <= 1'b0;
      end
      else
      begin
         primaryMode   <= modeDec;
         hitlessActive <= hsEff;                // [RL8]
         phaseRealign  <= !hsEff;               // [RL9]
      end
   end

   // Read data stand for the one cycle after the strobe, zero otherwise
   // Registered, so no path runs from the address pins to the data port
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         regRdData <= 32'h0000_0000;
      else
         regRdData <= rdMux;
   end

   // Configuration to the synthesizers
   assign synthARateKhz = synA_q;
   assign synthBConfig  = synB_q;
   assign diffARate     = diffA_q;
   assign diffBRate     = diffB_q;

   //==================================================================
   // Clock paths: buffered copies; a mux would glitch, so raw clocks pass straight
   assign synth_b_clock_a        = synthAClkRaw;          // [RL1]
   assign synth_b_clock_b        = synthBClkRaw;          // [RL2]
   assign feedback_copy_out      = primaryFeedbackClk;    // [RL3]
   assign secondary_ref_copy_out = secondarySelectedRef;  // [RL4] not hitless

   // Differential drivers; enable pin high (oen low) means driven, parked low while off
   assign diff_out_a_oen = !enAPin;                       // [RL13]
   assign diff_out_a_pos = enAPin & diffAClkRaw;
   assign diff_out_a_neg = enAPin & !diffAClkRaw;
   assign diff_out_b_oen = !enBPin;                       // [RL14]
   assign diff_out_b_pos = enBPin & diffBClkRaw;
   assign diff_out_b_neg = enBPin & !diffBClkRaw;

endmodule

// ==== tb/smpc_line_side.sv ====
// Model of the clock sources that feed the block's copy and driver paths
`timescale 1ns/1ps
module smpc_line_side
(
   output logic primaryFeedbackClk,
   output logic secondarySelectedRef,
   output logic synthAClkRaw,
   output logic synthBClkRaw,
   output logic diffAClkRaw,
   output logic diffBClkRaw
);
   // ==========================================================
   // Free-running sources
   // Unrelated half periods, so a copy cannot match its source by luck
   initial
   begin
      {primaryFeedbackClk, secondarySelectedRef, synthAClkRaw} = 3'b010;
      {synthBClkRaw, diffAClkRaw, diffBClkRaw} = 3'b110;
      fork
         forever #37 primaryFeedbackClk = ~primaryFeedbackClk;
         forever #41 secondarySelectedRef = ~secondarySelectedRef;
         forever #43 synthAClkRaw = ~synthAClkRaw;
         forever #47 synthBClkRaw = ~synthBClkRaw;
         forever #53 diffAClkRaw = ~diffAClkRaw;
         forever #59 diffBClkRaw = ~diffBClkRaw;
      join
   end
endmodule

// ==== tb/smpc_checker_assertions.sv ====
// Concurrent checks on the ports of the sync output and mode pin control block
`timescale 1ns/1ps
module smpc_checker
   import smpc_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [3:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWrite,
   input wire logic        synthAClkRaw,
   input wire logic        synthBClkRaw,
   input wire logic        synth_b_clock_a,
   input wire logic        synth_b_clock_b,
   input wire logic        primaryFeedbackClk,
   input wire logic        feedback_copy_out,
   input wire logic        secondarySelectedRef,
   input wire logic        secondary_ref_copy_out,
   input wire logic        diffAClkRaw,
   input wire logic        diff_out_a_pos,
   input wire logic        diff_out_a_neg,
   input wire logic        diff_out_a_oen,
   input wire logic        diff_out_a_enable,
   input wire logic        diffBClkRaw,
   input wire logic        diff_out_b_pos,
   input wire logic        diff_out_b_neg,
   input wire logic        diff_out_b_oen,
   input wire logic        hitlessActive,
   input wire logic        phaseRealign,
   input wire smpc_mode_t  primaryMode
);
   // ==========================================================
   // Properties, all in the one clock domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_ctrl_wr(int b); regWrite && regAddr == REG_CTRL && regWrData[b]; endsequence
   property p_synth_copy; synth_b_clock_a == synthAClkRaw && synth_b_clock_b == synthBClkRaw;
   endproperty
   a_synth_copy: assert property (p_synth_copy) else $error("synth copy differs");
   property p_fb_copy; feedback_copy_out == primaryFeedbackClk; endproperty
   a_fb_copy: assert property (p_fb_copy) else $error("feedback copy differs");
   property p_ref_copy; secondary_ref_copy_out == secondarySelectedRef; endproperty
   a_ref_copy: assert property (p_ref_copy) else $error("reference copy differs");
   property p_out_a; diff_out_a_oen ? !(diff_out_a_pos || diff_out_a_neg)
      : (diff_out_a_pos == diffAClkRaw && diff_out_a_neg != diffAClkRaw); endproperty
   a_out_a: assert property (p_out_a) else $error("output A driver wrong");
   property p_out_b; diff_out_b_oen ? !(diff_out_b_pos || diff_out_b_neg)
      : (diff_out_b_pos == diffBClkRaw && diff_out_b_neg != diffBClkRaw); endproperty
   a_out_b: assert property (p_out_b) else $error("output B driver wrong");
   // Seven quiet samples leave room for the three-flop synchroniser
   property p_en_sync; $stable(diff_out_a_enable) [*7] |-> diff_out_a_oen == !diff_out_a_enable;
   endproperty
   a_en_sync: assert property (p_en_sync) else $error("enable did not settle");
   property p_hs_pair; $past(resetn) |-> hitlessActive != phaseRealign; endproperty
   a_hs_pair: assert property (p_hs_pair) else $error("hitless and realign agree");
   property p_hs_reg; s_ctrl_wr(CTRL_HS_SRC) |-> ##2
      hitlessActive == $past(regWrData[CTRL_HS_SW], 2); endproperty
   a_hs_reg: assert property (p_hs_reg) else $error("hitless register ignored");
   property p_mode_reg; s_ctrl_wr(CTRL_MODE_SRC) |-> ##2
      primaryMode == 4'b0001 << $past(regWrData[CTRL_MODE_LO +: 2], 2); endproperty
   a_mode_reg: assert property (p_mode_reg) else $error("mode register ignored");
endmodule

bind smpc_top smpc_checker u_chk (.clk, .resetn, .regAddr, .regWrData, .regWrite,
   .synthAClkRaw, .synthBClkRaw, .synth_b_clock_a, .synth_b_clock_b, .primaryFeedbackClk,
   .feedback_copy_out, .secondarySelectedRef, .secondary_ref_copy_out, .diffAClkRaw,
   .diff_out_a_pos, .diff_out_a_neg, .diff_out_a_oen, .diff_out_a_enable, .hitlessActive,
   .phaseRealign, .primaryMode, .diffBClkRaw, .diff_out_b_pos, .diff_out_b_neg,
   .diff_out_b_oen);

// ==== tb/smpc_top_tb_top.sv ====
// Self-checking bench for the sync output and mode pin control block
`timescale 1ns/1ps
module smpc_top_tb_top
   import smpc_pkg::*;
;
   logic        clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, rdPend = 1'b0;
   logic        hitless_switch_enable = 1'b1, primary_mode_pin_lo = 1'b0;
   logic        primary_mode_pin_hi = 1'b1, diff_out_a_enable = 1'b1, diff_out_b_enable = 1'b1;
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0000_0000, regRdData, synthBConfig, v;
   logic [16:0] synthARateKhz;
   logic [2:0]  diffARate, diffBRate;
   logic        primaryFeedbackClk, secondarySelectedRef, synthAClkRaw, synthBClkRaw;
   logic        diffAClkRaw, diffBClkRaw, synth_b_clock_a, synth_b_clock_b, feedback_copy_out;
   logic        secondary_ref_copy_out, diff_out_a_pos, diff_out_a_neg, diff_out_a_oen;
   logic        diff_out_b_pos, diff_out_b_neg, diff_out_b_oen, hitlessActive, phaseRealign;
   smpc_mode_t  primaryMode;
   logic [31:0] expQ[$];
   int          num_errors = 0, n_compared = 0;
   integer      seed = 32'h3bad;

   smpc_top uut (.clk, .resetn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
      .hitless_switch_enable, .primary_mode_pin_lo, .primary_mode_pin_hi, .diff_out_a_enable,
      .diff_out_b_enable, .primaryFeedbackClk, .secondarySelectedRef, .synthAClkRaw,
      .synthBClkRaw, .diffAClkRaw, .diffBClkRaw, .synth_b_clock_a, .synth_b_clock_b,
      .synthARateKhz, .synthBConfig, .feedback_copy_out, .secondary_ref_copy_out,
      .diff_out_a_pos, .diff_out_a_neg, .diff_out_a_oen, .diff_out_b_pos, .diff_out_b_neg,
      .diff_out_b_oen, .diffARate, .diffBRate, .hitlessActive, .phaseRealign, .primaryMode);
   smpc_line_side partner (.primaryFeedbackClk, .secondarySelectedRef, .synthAClkRaw,
      .synthBClkRaw, .diffAClkRaw, .diffBClkRaw);

   // ==========================================================
   // Shared tasks
   task automatic chk(string nm, logic [31:0] e, logic [31:0] got);
      n_compared++;
      if (got !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, got);
      end
   endtask
   // A spare cycle after each strobe keeps every signal to one change per edge
   task automatic wr(logic [3:0] a, logic [31:0] d);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge clk);
      regWrite  <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      expQ.push_back(e);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(posedge clk);
   endtask
   task automatic do_reset(logic [1:0] strap);
      resetn <= 1'b0;
      {primary_mode_pin_hi, primary_mode_pin_lo} <= strap;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (10) @(posedge clk);
      chk("strap mode", 4'b0001 << strap, primaryMode);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Clock, and a watchdog far beyond the 166 cycles needed
   initial
   begin
      forever #50 clk = ~clk;
   end
   initial
   begin
      #(20000 * 100);
      num_errors++;
      complete_run();
   end
   // Read data stand only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rdPend)
         chk("read data", expQ.pop_front(), regRdData);
      rdPend <= regRead;
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      do_reset(2'b10);
      rd(REG_SYNTH_A, 32'h0000_0608);
      rd(REG_SYNTH_B, SYN_B_RST);
      rd(REG_DIFF, 32'h0000_0503);
      rd(REG_STATUS, 32'h0000_034B);
      rd(4'hF, 32'h0000_0000);
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 2 : (i == 1) ? 77760 : 8 * (1 + ($unsigned($random(seed)) % 9720));
         wr(REG_SYNTH_A, v);
         wr(REG_SYNTH_A, i[0] ? 32'h0001_2FC8 : 32'h0000_000C);
         chk("synth A rate", v, synthARateKhz);
      end
      wr(REG_SYNTH_B, 32'h0001_0004);
      wr(REG_SYNTH_B, 32'h0001_0000);
      chk("synth B config", 32'h0001_0004, synthBConfig);
      for (int c = 0; c < 7; c++)
      begin
         wr(REG_DIFF, {21'h0, 3'(5 - c % 6), 5'h0, 3'(c)});
         chk("diff A rate", (c < 6) ? c : 5, diffARate);
         chk("diff B rate", 5 - c % 6, diffBRate);
      end
      hitless_switch_enable <= 1'b0;
      repeat (8) @(posedge clk);
      chk("realign", 1, phaseRealign);
      wr(REG_CTRL, 32'h0000_0003);
      @(posedge clk);
      chk("hitless", 1, hitlessActive);
      for (int m = 0; m < 4; m++)
      begin
         {primary_mode_pin_hi, primary_mode_pin_lo} <= 2'(m);
         repeat (8) @(posedge clk);
         chk("pin mode", 4'b0001 << m, primaryMode);
         wr(REG_CTRL, {27'h0, 1'b1, 2'(3 - m), 2'b00});
         @(posedge clk);
         chk("register mode", 4'b0001 << (3 - m), primaryMode);
         wr(REG_CTRL, 32'h0000_0000);
      end
      for (int k = 1; k < 3; k++)
      begin
         {diff_out_a_enable, diff_out_b_enable} <= 2'(k);
         repeat (8) @(posedge clk);
         chk("output enables", 3 - k, {diff_out_a_oen, diff_out_b_oen});
      end
      do_reset(2'b11);
      rd(REG_DIFF, 32'h0000_0503);
      repeat (3) @(posedge clk);
      complete_run();
   end
endmodule
